// file: src/rp_bridge_consts.svh
// constants for the root port host bridge
`ifndef RP_BRIDGE_CONSTS_SVH
`define RP_BRIDGE_CONSTS_SVH
`define ADDR_CEIL_LSB       43
`define ADDR_CEIL_MSB       63
`define CFG_COMPAT_LIMIT    12'h100
`define CFG_BLOCK_MSB       11
`define CFG_BUS_LSB         20
`define CFG_DEV_LSB         15
`define CFG_FN_LSB          12
`define CPL_SC              3'h0
`define CPL_UR              3'h1
`define CPL_CRS             3'h2
`define TRAIN_TIME_NS       1000
`define CLK_PERIOD_NS       10
`define TRAIN_CYCLES        (`TRAIN_TIME_NS / `CLK_PERIOD_NS)
`define RATE_GEN1           3'h0
`define RATE_GEN4           3'h3
`define RATE_GEN5           3'h4
`define EQ_TAP_W            6
`define EQ_FS_DEFAULT       6'h3f
`define EQ_LF_DEFAULT       6'h0a
`endif

// file: src/rp_bridge_pkg.sv
// types for the root port host bridge
package rp_bridge_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [63:0] addr;
        logic [31:0] data;
    } upstream_req_type;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  bus;
        logic [4:0]  dev;
        logic [2:0]  fn;
        logic [11:0] offset;
        logic        extended;
        logic [31:0] data;
    } cfg_cycle_type;
    typedef struct packed {
        logic [5:0] pre;
        logic [5:0] main;
        logic [5:0] post;
    } eq_taps_type;
    typedef enum logic [2:0] {
        link_detect, link_polling, link_config, link_eq3, link_up
    } link_state_type;
    typedef enum logic [1:0] {
        cfg_idle, cfg_issue, cfg_wait
    } cfg_state_type;
endpackage

// file: src/rp_bridge.sv
// root port host bridge: address filter, config translation, link bring-up
// Operation
// - upstream read above 8192 GB ceiling gets Unsupported Request completion
// - upstream write above ceiling is dropped, never forwarded to memory
// - downstream 64-bit addresses always have bits 63:43 zero
// - first 256 bytes of each 4-KB config block alias legacy space
// - offsets 100h and above decode as extended config space
// - config cycle completing with retry status is issued again
// - link detects, negotiates and trains by itself after reset
// - memory-mapped config accesses become config cycles on the link
// - interrupts are plain message interrupts, no table variant
// - no hot-plug detection or slot control
// - bifurcated x16: second device lane 0 on port lane 8
// - reversed x8 on x16 port uses lanes 8:15, lane 15 is lane 0
// - reversed x4 on x8 port uses lanes 4:7, lane 7 is lane 0
// - 16 and 32 GT/s use 128b/130b encoding
// - x16 port runs 2.5, 5, 8, 16 and 32 GT/s
// - x8 port runs up to 16 GT/s, never 32 GT/s
// - three-tap transmit equalization bounded by swing and low-freq limits
// - far end performs adaptive phase 3 equalization, bridge applies the requested taps
// - multiple virtual channels only on fourth-generation port
// - high-speed ports lack time-value byte-order change, others have it
`timescale 1ns/1ns
`include "rp_bridge_consts.svh"
module rp_bridge #(
    parameter logic       IS_X16_PORT = 1'b1,
    parameter logic       IS_GEN4_PORT = 1'b0,
    parameter logic       IS_HIGH_SPEED = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire rp_bridge_pkg::upstream_req_type up_req,
    input  wire logic                          mmcfg_valid,
    input  wire logic                          mmcfg_write,
    input  wire logic [27:0]                   mmcfg_addr,
    input  wire logic [31:0]                   mmcfg_wdata,
    input  wire logic                          cfg_cpl_valid,
    input  wire logic [2:0]                    cfg_cpl_status,
    input  wire logic [31:0]                   cfg_cpl_data,
    input  wire logic                          partner_present,
    input  wire logic [2:0]                    partner_max_rate,
    input  wire logic                          eq3_done,
    input  wire logic [1:0]                    lane_mode,
    input  wire rp_bridge_pkg::eq_taps_type    eq_req,
    input  wire logic [63:0]                   down_addr_in,
    output logic                               mem_fwd_valid,
    output logic                               mem_fwd_write,
    output logic [63:0]                        mem_fwd_addr,
    output logic                               up_cpl_valid,
    output logic [2:0]                         up_cpl_status,
    output rp_bridge_pkg::cfg_cycle_type       cfg_cycle,
    output logic                               mmcfg_done,
    output logic [31:0]                        mmcfg_rdata,
    output logic                               mmcfg_busy,
    output logic [63:0]                        down_addr,
    output rp_bridge_pkg::link_state_type      link_state,
    output logic [2:0]                         link_rate,
    output logic                               enc_128b130b,
    output rp_bridge_pkg::eq_taps_type         eq_taps,
    output logic [3:0]                         lane_map0,
    output logic                               msix_enable,
    output logic                               hotplug_cap,
    output logic                               multi_vc,
    output logic                               ptm_byte_order
);
    // address above the 8192 GB ceiling
    function automatic logic above_ceiling(input logic [63:0] a);
        above_ceiling = |a[`ADDR_CEIL_MSB:`ADDR_CEIL_LSB];
    endfunction

    // clamp a rate to what the port supports
    function automatic logic [2:0] port_rate(input logic [2:0] r);
        logic [2:0] top;
        top = IS_X16_PORT ? `RATE_GEN5 : `RATE_GEN4;
        port_rate = (r > top) ? top : r;
    endfunction

    // bound a tap by the swing and low-frequency limits
    function automatic logic [5:0] bound_tap(input logic [5:0] t, input logic [5:0] lim);
        bound_tap = (t > lim) ? lim : t;
    endfunction

    rp_bridge_pkg::cfg_state_type  cfg_state;
    rp_bridge_pkg::cfg_cycle_type  next_cfg;
    logic [15:0]                   train_cnt;
    logic                          pres_s1;
    logic                          pres_s2;
    logic                          pres_s3;
    logic                          pres_ok;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_fwd_valid <= 1'b0;
            mem_fwd_write <= 1'b0;
            mem_fwd_addr  <= 64'h0;
            up_cpl_valid  <= 1'b0;
            up_cpl_status <= `CPL_SC;
        end
        else if (ce)
        begin
            mem_fwd_valid <= up_req.valid && !above_ceiling(up_req.addr);
            mem_fwd_write <= up_req.write;
            mem_fwd_addr  <= up_req.addr;
            up_cpl_valid  <= up_req.valid && !up_req.write && above_ceiling(up_req.addr);
            up_cpl_status <= (up_req.valid && above_ceiling(up_req.addr)) ? `CPL_UR : `CPL_SC;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            down_addr <= 64'h0;
        else if (ce)
        begin
            down_addr <= down_addr_in;
            down_addr[`ADDR_CEIL_MSB:`ADDR_CEIL_LSB] <= '0;
        end
    end

    always_comb
    begin
        next_cfg          = '0;
        next_cfg.valid    = 1'b1;
        next_cfg.write    = mmcfg_write;
        next_cfg.bus      = mmcfg_addr[27:`CFG_BUS_LSB];
        next_cfg.dev      = mmcfg_addr[19:`CFG_DEV_LSB];
        next_cfg.fn       = mmcfg_addr[14:`CFG_FN_LSB];
        next_cfg.offset   = {mmcfg_addr[`CFG_BLOCK_MSB:2], 2'b00};
        next_cfg.extended = next_cfg.offset >= `CFG_COMPAT_LIMIT;
        next_cfg.data     = mmcfg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_state   <= rp_bridge_pkg::cfg_idle;
            cfg_cycle   <= '0;
            mmcfg_done  <= 1'b0;
            mmcfg_rdata <= 32'h0;
            mmcfg_busy  <= 1'b0;
        end
        else if (ce)
        begin
            mmcfg_done      <= 1'b0;
            cfg_cycle.valid <= 1'b0;
            case (cfg_state)
                rp_bridge_pkg::cfg_idle:
                    if (mmcfg_valid && link_state == rp_bridge_pkg::link_up)
                    begin
                        cfg_cycle  <= next_cfg;
                        mmcfg_busy <= 1'b1;
                        cfg_state  <= rp_bridge_pkg::cfg_wait;
                    end
                rp_bridge_pkg::cfg_issue:
                begin
                    cfg_cycle.valid <= 1'b1;
                    cfg_state       <= rp_bridge_pkg::cfg_wait;
                end
                rp_bridge_pkg::cfg_wait:
                    if (cfg_cpl_valid)
                    begin
                        if (cfg_cpl_status == `CPL_CRS)
                            cfg_state <= rp_bridge_pkg::cfg_issue;
                        else
                        begin
                            mmcfg_rdata <= (cfg_cpl_status == `CPL_SC) ? cfg_cpl_data
                                                                       : 32'hffffffff;
                            mmcfg_done  <= 1'b1;
                            mmcfg_busy  <= 1'b0;
                            cfg_state   <= rp_bridge_pkg::cfg_idle;
                        end
                    end
                default:
                    cfg_state <= rp_bridge_pkg::cfg_idle;
            endcase
        end
    end

    // partner presence synchroniser
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pres_s1 <= 1'b0;
            pres_s2 <= 1'b0;
            pres_s3 <= 1'b0;
            pres_ok <= 1'b0;
        end
        else if (ce)
        begin
            pres_s1 <= partner_present;
            pres_s2 <= pres_s1;
            pres_s3 <= pres_s2;
            if (pres_s2 == pres_s3)
                pres_ok <= pres_s3;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            link_state   <= rp_bridge_pkg::link_detect;
            train_cnt    <= 16'h0;
            link_rate    <= `RATE_GEN1;
            enc_128b130b <= 1'b0;
        end
        else if (ce)
        begin
            case (link_state)
                rp_bridge_pkg::link_detect:
                    if (pres_ok)
                    begin
                        train_cnt  <= 16'h0;
                        link_state <= rp_bridge_pkg::link_polling;
                    end
                rp_bridge_pkg::link_polling:
                    if (train_cnt == 16'(`TRAIN_CYCLES - 1))
                        link_state <= rp_bridge_pkg::link_config;
                    else
                        train_cnt <= train_cnt + 16'h1;
                rp_bridge_pkg::link_config:
                begin
                    link_rate    <= port_rate(partner_max_rate);
                    enc_128b130b <= port_rate(partner_max_rate) >= `RATE_GEN4;
                    link_state   <= rp_bridge_pkg::link_eq3;
                end
                rp_bridge_pkg::link_eq3:
                    if (eq3_done)
                        link_state <= rp_bridge_pkg::link_up;
                rp_bridge_pkg::link_up:
                    if (!pres_ok)
                    begin
                        link_state   <= rp_bridge_pkg::link_detect;
                        link_rate    <= `RATE_GEN1;
                        enc_128b130b <= 1'b0;
                    end
                default:
                    link_state <= rp_bridge_pkg::link_detect;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            eq_taps <= '0;
        else if (ce && link_state == rp_bridge_pkg::link_eq3)
        begin
            eq_taps.pre  <= bound_tap(eq_req.pre, `EQ_LF_DEFAULT);
            eq_taps.main <= bound_tap(eq_req.main, `EQ_FS_DEFAULT);
            eq_taps.post <= bound_tap(eq_req.post, `EQ_LF_DEFAULT);
        end
    end

    // lane mapping: 0 normal, 1 bifurcated, 2 reversed
    always_ff @(posedge clk)
    begin
        if (rst)
            lane_map0 <= 4'h0;
        else if (ce)
        begin
            case (lane_mode)
                2'h1:    lane_map0 <= IS_X16_PORT ? 4'h8 : 4'h4;
                2'h2:    lane_map0 <= IS_X16_PORT ? 4'hf : 4'h7;
                default: lane_map0 <= 4'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            msix_enable    <= 1'b0;
            hotplug_cap    <= 1'b0;
            multi_vc       <= 1'b0;
            ptm_byte_order <= 1'b0;
        end
        else if (ce)
        begin
            msix_enable    <= 1'b0;
            hotplug_cap    <= 1'b0;
            multi_vc       <= IS_GEN4_PORT;
            ptm_byte_order <= !IS_HIGH_SPEED;
        end
    end

    // read above ceiling answered next cycle
    AST_UR_READ: assert property (@(posedge clk) disable iff (rst)
        ce && up_req.valid && !up_req.write && above_ceiling(up_req.addr)
        |=> up_cpl_valid && up_cpl_status == `CPL_UR)
        else $error("read above ceiling not refused");
    AST_DROP_WRITE: assert property (@(posedge clk) disable iff (rst)
        ce && up_req.valid && up_req.write && above_ceiling(up_req.addr) |=> !mem_fwd_valid)
        else $error("write above ceiling forwarded");
    AST_DOWN_ZERO: assert property (@(posedge clk) disable iff (rst)
        !above_ceiling(down_addr)) else $error("downstream address above ceiling");
    AST_EXT_DECODE: assert property (@(posedge clk) disable iff (rst)
        cfg_cycle.valid |-> cfg_cycle.extended == (cfg_cycle.offset >= `CFG_COMPAT_LIMIT))
        else $error("extended decode wrong");
    AST_RETRY: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_state == rp_bridge_pkg::cfg_wait && cfg_cpl_valid
        && cfg_cpl_status == `CPL_CRS ##1 ce |=> cfg_cycle.valid)
        else $error("retry not reissued");
    AST_RATE_CAP: assert property (@(posedge clk) disable iff (rst)
        link_rate <= (IS_X16_PORT ? `RATE_GEN5 : `RATE_GEN4)) else $error("rate above port limit");
    AST_ENCODING: assert property (@(posedge clk) disable iff (rst)
        link_state == rp_bridge_pkg::link_up |-> enc_128b130b == (link_rate >= `RATE_GEN4))
        else $error("encoding mismatch");
    AST_NO_MSIX: assert property (@(posedge clk) disable iff (rst)
        !msix_enable && !hotplug_cap) else $error("unsupported capability set");
    COV_UR: cover property (@(posedge clk) up_cpl_valid && up_cpl_status == `CPL_UR);
    COV_RETRY: cover property (@(posedge clk)
        cfg_state == rp_bridge_pkg::cfg_issue);
    COV_LINK_UP: cover property (@(posedge clk) link_state == rp_bridge_pkg::link_up);
endmodule // rp_bridge

// file: verif/endpoint_model.sv
// downstream endpoint model answering config cycles and link bring-up
`timescale 1ns/1ns
`include "rp_bridge_consts.svh"
module endpoint_model #(
    parameter logic [2:0] MAX_RATE = 3'h4
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire rp_bridge_pkg::cfg_cycle_type  cfg_cycle,
    input  wire rp_bridge_pkg::link_state_type link_state,
    input  wire logic [3:0]                    retries,
    input  wire logic [3:0]                    delay,
    output logic                               cpl_valid,
    output logic [2:0]                         cpl_status,
    output logic [31:0]                        cpl_data,
    output logic                               present,
    output logic [2:0]                         max_rate,
    output logic                               eq3_done
);
    logic        pending;
    logic [3:0]  wait_cnt;
    logic [3:0]  given;
    logic [11:0] offset;
    assign max_rate = MAX_RATE;
    // partner appears once reset is over
    always @(posedge clk)
        present <= !rst;
    // far end finishes its phase 3 tuning
    always @(posedge clk)
        eq3_done <= (link_state == rp_bridge_pkg::link_eq3) || (link_state == rp_bridge_pkg::link_up);
    // answers with retry status the asked number of times
    always @(posedge clk)
    begin
        cpl_valid <= 1'b0;
        if (rst)
        begin
            pending <= 1'b0;
            given <= 4'h0;
            cpl_status <= 3'h0;
            cpl_data <= 32'h0;
        end
        else if (cfg_cycle.valid)
        begin
            pending <= 1'b1;
            wait_cnt <= delay;
            offset <= cfg_cycle.offset;
        end
        else if (pending && wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else if (pending)
        begin
            pending <= 1'b0;
            cpl_valid <= 1'b1;
            cpl_data <= {20'hc0de0, offset};
            cpl_status <= (given < retries) ? `CPL_CRS : `CPL_SC;
            given <= (given < retries) ? given + 4'h1 : 4'h0;
        end
        else
        begin
            cpl_status <= ~cpl_status;
            cpl_data <= ~cpl_data;
        end
    end
endmodule // endpoint_model

// file: verif/testbench.sv
// self-checking bench for the root port host bridge
`timescale 1ns/1ns
`include "rp_bridge_consts.svh"
module testbench;
    logic                            clk = 1'b0;
    logic                            rst = 1'b1;
    logic                            ce = 1'b1;
    rp_bridge_pkg::upstream_req_type up_req = '0;
    logic                            mmcfg_valid = 1'b0;
    logic                            mmcfg_write = 1'b0;
    logic [27:0]                     mmcfg_addr = '0;
    logic [31:0]                     mmcfg_wdata = '0;
    logic                            cfg_cpl_valid;
    logic [2:0]                      cfg_cpl_status;
    logic [31:0]                     cfg_cpl_data;
    logic                            partner_present;
    logic [2:0]                      partner_max_rate;
    logic                            eq3_done;
    logic [1:0]                      lane_mode = 2'h0;
    rp_bridge_pkg::eq_taps_type      eq_req = '0;
    logic [63:0]                     down_addr_in = '0;
    logic                            mem_fwd_valid;
    logic                            mem_fwd_write;
    logic [63:0]                     mem_fwd_addr;
    logic                            up_cpl_valid;
    logic [2:0]                      up_cpl_status;
    rp_bridge_pkg::cfg_cycle_type    cfg_cycle;
    logic                            mmcfg_done;
    logic [31:0]                     mmcfg_rdata;
    logic                            mmcfg_busy;
    logic [63:0]                     down_addr;
    rp_bridge_pkg::link_state_type   link_state;
    logic [2:0]                      link_rate;
    logic                            enc_128b130b;
    rp_bridge_pkg::eq_taps_type      eq_taps;
    logic [3:0]                      lane_map0;
    logic                            msix_enable;
    logic                            hotplug_cap;
    logic                            multi_vc;
    logic                            ptm_byte_order;
    logic [3:0]                      retries = 4'h0;
    logic [3:0]                      delay = 4'h0;
    int                              cyc_count = 0;
    rp_bridge_pkg::cfg_cycle_type    last_cyc;
    int                              fails = 0;
    int                              num_checks = 0;

    always #5 clk = ~clk;

    rp_bridge uut (.clk(clk), .rst(rst), .ce(ce), .up_req(up_req), .mmcfg_valid(mmcfg_valid),
        .mmcfg_write(mmcfg_write), .mmcfg_addr(mmcfg_addr), .mmcfg_wdata(mmcfg_wdata),
        .cfg_cpl_valid(cfg_cpl_valid), .cfg_cpl_status(cfg_cpl_status),
        .cfg_cpl_data(cfg_cpl_data), .partner_present(partner_present),
        .partner_max_rate(partner_max_rate), .eq3_done(eq3_done), .lane_mode(lane_mode),
        .eq_req(eq_req), .down_addr_in(down_addr_in), .mem_fwd_valid(mem_fwd_valid),
        .mem_fwd_write(mem_fwd_write), .mem_fwd_addr(mem_fwd_addr),
        .up_cpl_valid(up_cpl_valid), .up_cpl_status(up_cpl_status), .cfg_cycle(cfg_cycle),
        .mmcfg_done(mmcfg_done), .mmcfg_rdata(mmcfg_rdata), .mmcfg_busy(mmcfg_busy),
        .down_addr(down_addr), .link_state(link_state), .link_rate(link_rate),
        .enc_128b130b(enc_128b130b), .eq_taps(eq_taps), .lane_map0(lane_map0),
        .msix_enable(msix_enable), .hotplug_cap(hotplug_cap), .multi_vc(multi_vc),
        .ptm_byte_order(ptm_byte_order));

    endpoint_model #(.MAX_RATE(`RATE_GEN5)) partner (.clk(clk), .rst(rst),
        .cfg_cycle(cfg_cycle), .link_state(link_state), .retries(retries), .delay(delay),
        .cpl_valid(cfg_cpl_valid), .cpl_status(cfg_cpl_status), .cpl_data(cfg_cpl_data),
        .present(partner_present), .max_rate(partner_max_rate), .eq3_done(eq3_done));

    always @(posedge clk)
        if (cfg_cycle.valid === 1'b1)
        begin
            cyc_count <= cyc_count + 1;
            last_cyc <= cfg_cycle;
        end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // link comes up by itself after reset
    task automatic t_link();
        check("state after reset", link_state, rp_bridge_pkg::link_detect);
        check("busy after reset", mmcfg_busy, 1'b0);
        for (int i = 0; i < 400 && link_state !== rp_bridge_pkg::link_up; i++)
            @(posedge clk) #1;
        check("link up", link_state, rp_bridge_pkg::link_up);
        check("rate", link_rate, `RATE_GEN5);
        check("encoding", enc_128b130b, 1'b1);
    endtask

    // upstream requests filtered at the ceiling
    task automatic up_xfer(input logic wr, input logic [63:0] a, input logic fwd, input logic ur);
        logic f;
        logic u;
        logic [63:0] fa;
        logic w;
        f = 1'b0;
        u = 1'b0;
        fa = '0;
        w = 1'b0;
        @(posedge clk) #1;
        up_req = '{1'b1, wr, a, 32'h5a5a_0001};
        repeat (3)
        begin
            @(posedge clk) #1;
            up_req.valid = 1'b0;
            if (mem_fwd_valid === 1'b1)
            begin
                f = 1'b1;
                fa = mem_fwd_addr;
                w = mem_fwd_write;
            end
            if (up_cpl_valid === 1'b1 && up_cpl_status === `CPL_UR)
                u = 1'b1;
        end
        check("forwarded", f, fwd);
        check("unsupported", u, ur);
        if (fwd)
        begin
            check("forward addr", fa, a);
            check("forward write", w, wr);
        end
    endtask

    // config access becomes config cycles, retried on retry status
    task automatic t_cfg(input logic wr, input logic [7:0] b, input logic [4:0] d,
                         input logic [2:0] fn, input logic [11:0] off, input logic [3:0] rt);
        logic done;
        logic [31:0] rd;
        done = 1'b0;
        rd = '0;
        retries = rt;
        delay = rt + 4'h2;
        cyc_count = 0;
        @(posedge clk) #1;
        mmcfg_valid = 1'b1;
        mmcfg_write = wr;
        mmcfg_addr = {b, d, fn, off};
        mmcfg_wdata = 32'h1234_0000 | off;
        for (int i = 0; i < 200 && !done; i++)
        begin
            @(posedge clk) #1;
            if (i == 0)
                check("busy", mmcfg_busy, 1'b1);
            done = (mmcfg_done === 1'b1);
            rd = mmcfg_rdata;
        end
        mmcfg_valid = 1'b0;
        check("done", done, 1'b1);
        check("busy cleared", mmcfg_busy, 1'b0);
        check("cycles", cyc_count, rt + 1);
        check("bus", last_cyc.bus, b);
        check("dev", last_cyc.dev, d);
        check("fn", last_cyc.fn, fn);
        check("offset", last_cyc.offset, off);
        check("extended", last_cyc.extended, off >= `CFG_COMPAT_LIMIT);
        check("write", last_cyc.write, wr);
        if (wr)
            check("wdata", last_cyc.data, 32'h1234_0000 | off);
        else
            check("rdata", rd, 32'hc0de_0000 | off);
    endtask

    // mid-run reset, link retrains and takes the requested taps
    task automatic retrain();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_link();
    endtask

    // fixed mappings and limits, taps taken while training
    task automatic t_misc();
        down_addr_in = 64'hffff_ffff_ffff_ffff;
        eq_req = '{6'h3f, 6'h3f, 6'h3f};
        lane_mode = 2'h1;
        retrain();
        check("down addr", down_addr, 64'h0000_07ff_ffff_ffff);
        check("taps clamp", eq_taps, {6'h0a, 6'h3f, 6'h0a});
        check("bifurcated lane", lane_map0, 4'h8);
        eq_req = '{6'h05, 6'h20, 6'h07};
        lane_mode = 2'h2;
        retrain();
        check("taps", eq_taps, {6'h05, 6'h20, 6'h07});
        check("reversed lane", lane_map0, 4'hf);
        check("msi only", msix_enable, 1'b0);
        check("no hotplug", hotplug_cap, 1'b0);
        check("single vc", multi_vc, 1'b0);
        check("time byte order", ptm_byte_order, 1'b0);
        // clock enable low freezes state
        ce = 1'b0;
        down_addr_in = 64'h0;
        lane_mode = 2'h0;
        repeat (3) @(posedge clk);
        #1;
        check("frozen addr", down_addr, 64'h0000_07ff_ffff_ffff);
        check("frozen lane", lane_map0, 4'hf);
        ce = 1'b1;
    endtask

    initial
    begin
        #100000;
        fails++;
        close_out();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        t_link();
        up_xfer(1'b0, 64'h0000_07ff_ffff_fffc, 1'b1, 1'b0);
        up_xfer(1'b0, 64'h0000_0800_0000_0000, 1'b0, 1'b1);
        up_xfer(1'b0, 64'h8000_0000_0000_1000, 1'b0, 1'b1);
        up_xfer(1'b1, 64'h0000_0800_0000_0040, 1'b0, 1'b0);
        up_xfer(1'b1, 64'h0000_0000_1000_0040, 1'b1, 1'b0);
        t_cfg(1'b0, 8'h03, 5'h05, 3'h2, 12'h0fc, 4'h0);
        t_cfg(1'b0, 8'hff, 5'h1f, 3'h7, 12'h100, 4'h1);
        t_cfg(1'b1, 8'h01, 5'h00, 3'h0, 12'hffc, 4'h2);
        t_misc();
        close_out();
    end
endmodule // testbench
